// [logic/eac_pkg.sv]
// constants and types shared by the effective-address unit
package eac_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int EAC_DW        = 32;
  localparam int EAC_NUM_DREG  = 8;
  localparam int EAC_NUM_AREG  = 8;
  localparam int EAC_BLOCK_LSB = 4;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [31:0] EAC_RST_WORD = 32'h0000_0000;
  localparam logic [1:0]  EAC_RST_NWRD = 2'h0;

  // ****************************************************************
  // addressing modes
  // ****************************************************************
  typedef enum logic [3:0] {
    EAC_M_DREG  = 4'h0,  // data register direct
    EAC_M_AREG  = 4'h1,  // address register direct
    EAC_M_IND   = 4'h2,  // register indirect
    EAC_M_DISP  = 4'h3,  // base plus 16-bit displacement
    EAC_M_IDX8  = 4'h4,  // base plus 8-bit displacement plus index
    EAC_M_IDXBD = 4'h5,  // base plus base_disp plus index
    EAC_M_MPOST = 4'h6,  // memory indirect, index after fetch
    EAC_M_MPRE  = 4'h7,  // memory indirect, index before fetch
    EAC_M_ABS   = 4'h8   // absolute, address from base_disp
  } eac_mode_t;

  // displacement size selector
  typedef enum logic [1:0] {
    EAC_D_NONE = 2'h0,
    EAC_D_WORD = 2'h1,
    EAC_D_LONG = 2'h2
  } eac_dsize_t;

  // immediate operand size
  typedef enum logic [1:0] {
    EAC_S_BYTE = 2'h0,
    EAC_S_WORD = 2'h1,
    EAC_S_LONG = 2'h2
  } eac_osize_t;

  // floating-point operations carried out in hardware
  typedef enum logic [4:0] {
    EAC_F_ABS  = 5'h00, EAC_F_ADD  = 5'h01, EAC_F_BCC  = 5'h02,
    EAC_F_CMP  = 5'h03, EAC_F_DBCC = 5'h04, EAC_F_DIV  = 5'h05,
    EAC_F_MOVE = 5'h06, EAC_F_MOVM = 5'h07, EAC_F_MUL  = 5'h08,
    EAC_F_NEG  = 5'h09, EAC_F_REST = 5'h0A, EAC_F_SAVE = 5'h0B,
    EAC_F_SCC  = 5'h0C, EAC_F_SQRT = 5'h0D, EAC_F_SUB  = 5'h0E,
    EAC_F_TRAP = 5'h0F, EAC_F_TST  = 5'h10
  } eac_fpop_t;

  // calculation sequencer, gray along idle-calc-fetch-done
  typedef enum logic [1:0] {
    EAC_IDLE  = 2'b00,
    EAC_CALC  = 2'b01,
    EAC_FETCH = 2'b11,
    EAC_DONE  = 2'b10
  } eac_state_t;

endpackage

// [logic/eac_effective_address.sv]
// effective-address generator with register file and operand sizing
// Behaviour
// - short displacements of 8 or 16 bits are sign-extended and added in.
// - any data or address register can be the index, word or long sized.
// - the index is multiplied by a scale of 1, 2, 4 or 8 before adding.
// - an optional 16- or 32-bit base displacement joins the sum.
// - an optional 16- or 32-bit outer displacement is added after fetch.
// - memory-indirect modes fetch a long word used as the next pointer.
// - immediate operands are sized to 8, 16 or 32 bits by operation size.
// - eight data and eight address registers; a base is always an address register or the program counter.
// - a block copy works on one aligned 16-byte block per execution.
// - only the common floating-point subset runs here, the rest traps.
// - addresses may be formed relative to the program counter.
module eac_effective_address
  import eac_pkg::*;
(
  input  wire logic        sys_clk,       // processor clock
  input  wire logic        reset_n,       // async reset, active low
  input  wire logic        ce,            // clock enable
  input  wire logic        regWrEn,       // register file write
  input  wire logic [3:0]  regWrSel,      // {addr, number}
  input  wire logic [31:0] regWrData,     // write data
  input  wire logic        eaStart,       // start a calculation
  input  wire eac_mode_t   eaMode,        // addressing mode
  input  wire logic        pcRel,         // base is program counter
  input  wire logic [31:0] pcIn,          // program counter value
  input  wire logic [2:0]  addr_reg_n,    // base address register
  input  wire logic [2:0]  data_reg_n,    // data register for direct
  input  wire logic [15:0] shortDisp,     // 8/16-bit displacement
  input  wire logic        idxIsAddr,     // index is address register
  input  wire logic [2:0]  index_reg_select, // index register number
  input  wire logic        idxLong,       // index is long sized
  input  wire logic [1:0]  idxScale,      // log2 of scale
  input  wire logic [31:0] base_disp,     // base displacement
  input  wire eac_dsize_t  baseDispSize,  // base displacement size
  input  wire logic [31:0] outer_disp,    // outer displacement
  input  wire eac_dsize_t  outerDispSize, // outer displacement size
  input  wire logic        block_copy_sixteen, // block copy access
  input  wire logic        memRdAck,      // memory read done
  input  wire logic [31:0] memRdData,     // fetched long word
  input  wire logic        immValid,      // immediate present
  input  wire logic [31:0] immRaw,        // immediate stream bits
  input  wire eac_osize_t  immSize,       // operation size
  input  wire logic        fpValid,       // fp operation issued
  input  wire logic [4:0]  fpOp,          // fp operation code
  output logic             eaReady,       // idle, start allowed
  output logic             memRdReq,      // memory read request
  output logic [31:0]      memRdAddr,     // memory read address
  output logic             eaValid,       // result strobe
  output logic [31:0]      eaOut,         // address or register value
  output logic [31:0]      immOut,        // sized immediate
  output logic [1:0]       immWords,      // extension words used
  output logic             fpHwGo,        // fp op run in hardware
  output logic             fpEmuTrap      // fp op left to software
);

  default disable iff (!reset_n);

  // ****************************************************************
  // helper functions
  // ****************************************************************
  function automatic logic [31:0] sext8(input logic [7:0] v);
    sext8 = {{24{v[7]}}, v};
  endfunction

  function automatic logic [31:0] sext16(input logic [15:0] v);
    sext16 = {{16{v[15]}}, v};
  endfunction

  function automatic logic [31:0] sizeDisp(input logic [31:0] v,
                                           input eac_dsize_t s);
    case (s)
      EAC_D_WORD: sizeDisp = sext16(v[15:0]);
      EAC_D_LONG: sizeDisp = v;
      default:    sizeDisp = EAC_RST_WORD;
    endcase
  endfunction

  // ****************************************************************
  // register file
  // ****************************************************************
  logic [31:0] regs [EAC_NUM_DREG + EAC_NUM_AREG];

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < EAC_NUM_DREG + EAC_NUM_AREG; i++) begin
        regs[i] <= EAC_RST_WORD;
      end
    end else if (ce && regWrEn) begin
      regs[regWrSel] <= regWrData;
    end
  end

  // ****************************************************************
  // latched request
  // ****************************************************************
  eac_state_t  state_r, state_nxt;
  eac_mode_t   mode_r;
  logic        pcRel_r, idxIsAddr_r, idxLong_r, blk_r;
  logic [2:0]  baseN_r, dataN_r, idxN_r;
  logic [1:0]  scale_r;
  logic [15:0] sdisp_r;
  logic [31:0] pc_r, bd_r, od_r, inter_r, eaR;
  logic        validR;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_r      <= EAC_M_DREG;
      pcRel_r     <= 1'b0;
      idxIsAddr_r <= 1'b0;
      idxLong_r   <= 1'b0;
      blk_r       <= 1'b0;
      baseN_r     <= 3'h0;
      dataN_r     <= 3'h0;
      idxN_r      <= 3'h0;
      scale_r     <= 2'h0;
      sdisp_r     <= 16'h0000;
      pc_r        <= EAC_RST_WORD;
      bd_r        <= EAC_RST_WORD;
      od_r        <= EAC_RST_WORD;
    end else if (ce && eaStart && state_r == EAC_IDLE) begin
      mode_r      <= eaMode;
      pcRel_r     <= pcRel;
      idxIsAddr_r <= idxIsAddr;
      idxLong_r   <= idxLong;
      blk_r       <= block_copy_sixteen;
      baseN_r     <= addr_reg_n;
      dataN_r     <= data_reg_n;
      idxN_r      <= index_reg_select;
      scale_r     <= idxScale;
      sdisp_r     <= shortDisp;
      pc_r        <= pcIn;
      bd_r        <= sizeDisp(base_disp, baseDispSize);
      od_r        <= sizeDisp(outer_disp, outerDispSize);
    end
  end

  // ****************************************************************
  // address arithmetic
  // ****************************************************************
  wire        isMem   = (mode_r == EAC_M_MPOST) || (mode_r == EAC_M_MPRE);
  wire        useIdx  = (mode_r == EAC_M_IDX8) || (mode_r == EAC_M_IDXBD) ||
                        (mode_r == EAC_M_MPRE);
  wire        useBd   = (mode_r == EAC_M_IDXBD) || isMem ||
                        (mode_r == EAC_M_ABS);
  wire [31:0] idxRaw  = regs[{idxIsAddr_r, idxN_r}];
  wire [31:0] idxVal  = idxLong_r ? idxRaw : sext16(idxRaw[15:0]);
  wire [31:0] idxScl  = idxVal << scale_r;
  wire [31:0] baseVal = pcRel_r ? pc_r : regs[{1'b1, baseN_r}];
  wire [31:0] dispT   = (mode_r == EAC_M_DISP) ? sext16(sdisp_r) :
                        (mode_r == EAC_M_IDX8) ? sext8(sdisp_r[7:0]) :
                        EAC_RST_WORD;
  wire [31:0] baseT   = (mode_r == EAC_M_ABS) ? EAC_RST_WORD : baseVal;
  wire [31:0] bdT     = useBd ? bd_r : EAC_RST_WORD;
  wire [31:0] idxT    = useIdx ? idxScl : EAC_RST_WORD;
  wire [31:0] sumDir  = baseT + dispT + bdT + idxT;
  wire [31:0] regDir  = (mode_r == EAC_M_DREG) ? regs[{1'b0, dataN_r}] :
                        regs[{1'b1, baseN_r}];
  wire        isReg   = (mode_r == EAC_M_DREG) || (mode_r == EAC_M_AREG);
  wire [31:0] postIdx = (mode_r == EAC_M_MPOST) ? idxScl : EAC_RST_WORD;
  wire [31:0] sumMem  = memRdData + postIdx + od_r;
  // block address aligned to sixteen bytes
  wire [31:0] blkMask = ~((32'h1 << EAC_BLOCK_LSB) - 32'h1);
  wire [31:0] calcEa  = isReg ? regDir : sumDir;
  wire [31:0] eaRaw   = (state_r == EAC_FETCH) ? sumMem : calcEa;
  wire [31:0] eaNxt   = (blk_r && !isReg) ? (eaRaw & blkMask) : eaRaw;

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      EAC_IDLE:  if (eaStart) state_nxt = EAC_CALC;
      EAC_CALC:  state_nxt = isMem ? EAC_FETCH : EAC_DONE;
      EAC_FETCH: if (memRdAck) state_nxt = EAC_DONE;
      default:   state_nxt = EAC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= EAC_IDLE;
      inter_r <= EAC_RST_WORD;
      eaR     <= EAC_RST_WORD;
      validR  <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      validR  <= (state_nxt == EAC_DONE) && (state_r != EAC_DONE);
      if (state_r == EAC_CALC && isMem) inter_r <= sumDir;
      if (state_r == EAC_CALC && !isMem) eaR <= eaNxt;
      if (state_r == EAC_FETCH && memRdAck) eaR <= eaNxt;
    end
  end

  assign eaReady   = (state_r == EAC_IDLE);
  assign memRdReq  = (state_r == EAC_FETCH);
  assign memRdAddr = inter_r;
  assign eaValid   = validR;
  assign eaOut     = eaR;

  // ****************************************************************
  // immediate sizing and fp dispatch
  // ****************************************************************
  logic [31:0] immR;
  logic [1:0]  immW_r;
  logic        fpHw_r, fpEmu_r;
  wire [31:0]  immNxt = (immSize == EAC_S_BYTE) ? {24'h0, immRaw[7:0]} :
                        (immSize == EAC_S_WORD) ? {16'h0, immRaw[15:0]} :
                        immRaw;
  wire [1:0]   immWN  = (immSize == EAC_S_LONG) ? 2'h2 : 2'h1;
  wire         fpInHw = (fpOp <= EAC_F_TST);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      immR    <= EAC_RST_WORD;
      immW_r  <= EAC_RST_NWRD;
      fpHw_r  <= 1'b0;
      fpEmu_r <= 1'b0;
    end else if (ce) begin
      if (immValid) begin
        immR   <= immNxt;
        immW_r <= immWN;
      end
      fpHw_r  <= fpValid && fpInHw;
      fpEmu_r <= fpValid && !fpInHw;
    end
  end

  assign immOut    = immR;
  assign immWords  = immW_r;
  assign fpHwGo    = fpHw_r;
  assign fpEmuTrap = fpEmu_r;

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence s_calc_mem;
    ce && state_r == EAC_CALC && isMem;
  endsequence
  sequence s_fetch_done;
    ce && state_r == EAC_FETCH && memRdAck;
  endsequence

  short_disp_add_a: assert property (@(posedge sys_clk)
    (ce && state_r == EAC_CALC && mode_r == EAC_M_IDX8 && !blk_r) |=>
    eaR == $past(baseVal) + $past(sext8(sdisp_r[7:0])) + $past(idxScl))
    else $error("8-bit displacement sum wrong");
  index_word_ext_a: assert property (@(posedge sys_clk)
    !idxLong_r |-> idxVal[31:16] == {16{idxRaw[15]}})
    else $error("word index not sign extended");
  index_scale_a: assert property (@(posedge sys_clk)
    idxScl == idxVal * (32'h1 << scale_r))
    else $error("index scale wrong");
  base_disp_abs_a: assert property (@(posedge sys_clk)
    (ce && state_r == EAC_CALC && mode_r == EAC_M_ABS && !blk_r) |=>
    eaR == $past(bd_r))
    else $error("absolute address not base displacement");
  indirect_req_a: assert property (@(posedge sys_clk)
    s_calc_mem |=> memRdReq && memRdAddr == $past(sumDir))
    else $error("indirect fetch not requested");
  outer_after_a: assert property (@(posedge sys_clk)
    (s_fetch_done and (##0 !blk_r)) |=>
    eaR == $past(memRdData) + $past(postIdx) + $past(od_r) ##1 !eaValid)
    else $error("outer displacement sum wrong");
  block_align_a: assert property (@(posedge sys_clk)
    (eaValid && blk_r && !isReg) |-> eaOut[3:0] == 4'h0)
    else $error("block address not aligned");
  imm_size_a: assert property (@(posedge sys_clk)
    (ce && immValid && immSize == EAC_S_BYTE) |=>
    immOut[31:8] == 24'h0 && immWords == 2'h1)
    else $error("byte immediate not sized");
  fp_split_a: assert property (@(posedge sys_clk)
    !(fpHwGo && fpEmuTrap))
    else $error("fp op both run and trapped");
  pc_rel_a: assert property (@(posedge sys_clk)
    (ce && state_r == EAC_CALC && pcRel_r && mode_r == EAC_M_DISP && !blk_r)
    |=> eaR == $past(pc_r) + $past(sext16(sdisp_r)))
    else $error("pc relative address wrong");

endmodule // eac_effective_address

// [verification/eac_mem_model.sv]
// memory read responder on the fetch side of the effective-address unit
module eac_mem_model (
  input  wire logic        sys_clk,   // processor clock
  input  wire logic        reset_n,   // async reset, active low
  input  wire logic        memRdReq,  // read request level
  input  wire logic [31:0] memRdAddr, // read address
  output logic             memRdAck,  // read done
  output logic [31:0]      memRdData  // fetched long word
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [2:0]  waitCnt_r;
  logic [31:0] lastData_r;

  // a released data bus shows the inverse of the last word, never a hold
  assign memRdData = memRdAck ? lastData_r : ~lastData_r;

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      memRdAck   <= 1'b0;
      waitCnt_r  <= 3'h0;
      lastData_r <= 32'h0000_0000;
    end else if (memRdReq && !memRdAck) begin
      if (waitCnt_r == 3'h0) begin
        memRdAck   <= 1'b1;
        // contents are a fixed scramble of the address
        lastData_r <= {memRdAddr[15:0], memRdAddr[31:16]} ^ 32'h5A5A_C3C3;
      end else begin
        waitCnt_r <= waitCnt_r - 3'h1;
      end
    end else begin
      memRdAck  <= 1'b0;
      waitCnt_r <= 3'($urandom_range(0, 5));
    end
  end
endmodule // eac_mem_model

// [verification/effective_address_calc_tb.sv]
// self-checking bench for the effective-address generator
module effective_address_calc_tb
  import eac_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic sys_clk, reset_n, ce, regWrEn, eaStart, pcRel, idxIsAddr, idxLong;
  logic block_copy_sixteen, memRdAck, immValid, fpValid;
  logic [3:0] regWrSel;
  logic [2:0] addr_reg_n, data_reg_n, index_reg_select;
  logic [1:0] idxScale, immWords;
  logic [15:0] shortDisp;
  logic [4:0] fpOp;
  logic [31:0] regWrData, pcIn, base_disp, outer_disp, memRdData, immRaw;
  logic [31:0] memRdAddr, eaOut, immOut;
  eac_mode_t eaMode;
  eac_dsize_t baseDispSize, outerDispSize;
  eac_osize_t immSize;
  logic eaReady, memRdReq, eaValid, fpHwGo, fpEmuTrap;
  logic [31:0] rf [16];
  int err_count, n_tests, cycCnt;

  eac_effective_address i_eac_effective_address (
    .sys_clk(sys_clk), .reset_n(reset_n), .ce(ce), .regWrEn(regWrEn),
    .regWrSel(regWrSel), .regWrData(regWrData), .eaStart(eaStart),
    .eaMode(eaMode), .pcRel(pcRel), .pcIn(pcIn), .addr_reg_n(addr_reg_n),
    .data_reg_n(data_reg_n), .shortDisp(shortDisp), .idxIsAddr(idxIsAddr),
    .index_reg_select(index_reg_select), .idxLong(idxLong),
    .idxScale(idxScale), .base_disp(base_disp), .baseDispSize(baseDispSize),
    .outer_disp(outer_disp), .outerDispSize(outerDispSize),
    .block_copy_sixteen(block_copy_sixteen), .memRdAck(memRdAck),
    .memRdData(memRdData), .immValid(immValid), .immRaw(immRaw),
    .immSize(immSize), .fpValid(fpValid), .fpOp(fpOp), .eaReady(eaReady),
    .memRdReq(memRdReq), .memRdAddr(memRdAddr), .eaValid(eaValid),
    .eaOut(eaOut), .immOut(immOut), .immWords(immWords), .fpHwGo(fpHwGo),
    .fpEmuTrap(fpEmuTrap));

  eac_mem_model i_eac_mem_model (
    .sys_clk(sys_clk), .reset_n(reset_n), .memRdReq(memRdReq),
    .memRdAddr(memRdAddr), .memRdAck(memRdAck), .memRdData(memRdData));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycCnt++;
    if (cycCnt == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [31:0] sz(logic [31:0] v, eac_dsize_t s);
    return (s == EAC_D_NONE) ? 32'h0 :
           (s == EAC_D_WORD) ? {{16{v[15]}}, v[15:0]} : v;
  endfunction

  // ****************************************************************
  // reference address arithmetic, fa returns the fetch address
  // ****************************************************************
  function automatic logic [31:0] calc(output logic [31:0] fa);
    logic [31:0] b, x, bd, od, r, md;
    b  = pcRel ? pcIn : rf[{1'b1, addr_reg_n}];
    x  = rf[{idxIsAddr, index_reg_select}];
    if (!idxLong) x = {{16{x[15]}}, x[15:0]};
    x  = x << idxScale;
    bd = sz(base_disp, baseDispSize);
    od = sz(outer_disp, outerDispSize);
    fa = (eaMode == EAC_M_MPRE) ? b + bd + x : b + bd;
    md = {fa[15:0], fa[31:16]} ^ 32'h5A5A_C3C3;
    case (eaMode)
      EAC_M_DREG:  r = rf[{1'b0, data_reg_n}];
      EAC_M_AREG:  r = rf[{1'b1, addr_reg_n}];
      EAC_M_IND:   r = b;
      EAC_M_DISP:  r = b + {{16{shortDisp[15]}}, shortDisp};
      EAC_M_IDX8:  r = b + {{24{shortDisp[7]}}, shortDisp[7:0]} + x;
      EAC_M_IDXBD: r = b + bd + x;
      EAC_M_MPOST: r = md + x + od;
      EAC_M_MPRE:  r = md + od;
      default:     r = bd;
    endcase
    if (block_copy_sixteen && eaMode > EAC_M_AREG) r[3:0] = 4'h0;
    return r;
  endfunction

  task automatic wrReg(logic [3:0] s, logic [31:0] d);
    regWrEn   = 1'b1;
    regWrSel  = s;
    regWrData = d;
    rf[s]     = d;
    @(negedge sys_clk);
  endtask

  task automatic rnd(int m);
    eaMode = eac_mode_t'(m);
    {pcRel, idxIsAddr, idxLong, idxScale} = 5'($urandom);
    {addr_reg_n, data_reg_n, index_reg_select} = 9'($urandom);
    {pcIn, base_disp, outer_disp} = {$urandom, $urandom, $urandom};
    shortDisp = 16'($urandom);
    baseDispSize = eac_dsize_t'($urandom_range(0, 2));
    outerDispSize = eac_dsize_t'($urandom_range(0, 2));
    block_copy_sixteen = ($urandom_range(0, 2) == 0);
  endtask

  task automatic do_ea();
    logic [31:0] expOut, expAddr;
    int n;
    expOut = calc(expAddr);
    eaStart = 1'b1;
    @(negedge sys_clk);
    eaStart = 1'b0;
    n = 1;
    while (eaValid !== 1'b1 && n < 40) begin
      if (memRdReq === 1'b1)
        check("memRdAddr", memRdAddr, expAddr);
      @(negedge sys_clk);
      n++;
    end
    check("eaOut", eaOut, expOut);
    if (eaMode < EAC_M_MPOST || eaMode == EAC_M_ABS)
      check("latency", 32'(n), 32'h2);
    @(negedge sys_clk);
    check("eaValid", eaValid, 32'h0);
    check("eaReady", eaReady, 32'h1);
  endtask

  task automatic do_imm(int s);
    immValid = 1'b1;
    immRaw   = $urandom;
    immSize  = eac_osize_t'(s);
    @(negedge sys_clk);
    immValid = 1'b0;
    check("immOut", immOut, (s == 0) ? {24'h0, immRaw[7:0]} :
          (s == 1) ? {16'h0, immRaw[15:0]} : immRaw);
    check("immWords", immWords, (s == 2) ? 32'h2 : 32'h1);
  endtask

  task automatic do_fp(int op, logic en);
    ce      = en;
    fpValid = 1'b1;
    fpOp    = 5'(op);
    @(negedge sys_clk);
    fpValid = 1'b0;
    ce      = 1'b1;
    check("fpHwGo", fpHwGo, en && op <= 16);
    check("fpEmuTrap", fpEmuTrap, en && op > 16);
    @(negedge sys_clk);
    check("fpPulse", {fpHwGo, fpEmuTrap}, 32'h0);
  endtask

  initial begin
    void'($urandom(63));
    {reset_n, regWrEn, eaStart, immValid, fpValid, ce} = 6'b000001;
    {regWrSel, regWrData, immRaw, fpOp} = '0;
    rnd(0);
    immSize = EAC_S_BYTE;
    repeat (8) @(negedge sys_clk);
    reset_n = 1'b1;
    check("rstReady", {eaReady, eaValid, memRdReq}, 32'h4);
    check("rstOut", eaOut, EAC_RST_WORD);
    // all sixteen registers written back to back
    for (int i = 0; i < 16; i++) wrReg(4'(i), $urandom);
    wrReg(4'h0, 32'h0000_8000);
    wrReg(4'hF, 32'h8000_0001);
    regWrEn = 1'b0;
    // negative byte displacement with a word index scaled by eight
    rnd(4);
    {pcRel, idxIsAddr, index_reg_select, idxLong, idxScale} = 8'h03;
    shortDisp = 16'h0080;
    do_ea();
    // negative word displacement off the program counter, block aligned
    rnd(3);
    {pcRel, shortDisp, block_copy_sixteen} = {1'b1, 16'h8000, 1'b1};
    do_ea();
    for (int i = 0; i < 300; i++) begin
      if (i % 8 == 7) begin
        wrReg(4'($urandom), $urandom);
        regWrEn = 1'b0;
      end
      rnd(i < 9 ? i : $urandom_range(0, 8));
      do_ea();
    end
    for (int i = 0; i < 30; i++) do_imm(i % 3);
    for (int i = 0; i < 32; i++) do_fp(i, 1'b1);
    do_fp(0, 1'b0);
    tally_and_finish();
  end
endmodule // effective_address_calc_tb
